// [include/mbp_pkg.sv]
// mbp_pkg: register map, field layout, value formats and helpers of the modbus rtu port
// assumes a 100 MHz core clock feeding the bit-rate dividers
package mbp_pkg;
  localparam int CLK_HZ = 100000000;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_POLL = 8'h04;
  localparam logic [7:0] REG_TIME = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_SEL  = 8'h10;
  localparam logic [7:0] REG_VAL  = 8'h14;
  localparam logic [7:0] REG_WORD = 8'h18;
  // field positions
  localparam int CTRL_ADDR = 0;
  localparam int CTRL_ROLE = 8;
  localparam int CTRL_FRAME = 10;
  localparam int CTRL_BAUD = 12;
  localparam int CTRL_FN = 15;
  localparam int POLL_BASE = 0;
  localparam int POLL_CNT = 16;
  localparam int POLL_FMT = 24;
  localparam int TIME_TMO = 0;
  localparam int TIME_PER = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_TMO = 1;
  localparam int STAT_BAD = 8;
  localparam int STAT_GOOD = 16;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001; // address 1, responder, 8n2, 4800
  localparam logic [31:0] POLL_RST = 32'h0000_0000;
  localparam logic [31:0] TIME_RST = 32'h000A_0064; // 1 s period, 100 ms timeout
  // protocol constants
  localparam logic [7:0]  FN_HOLD  = 8'h03;
  localparam logic [7:0]  FN_INPUT = 8'h04;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [5:0]  MAX_VALS = 6'h32;
  localparam int NWORDS = 128;
  localparam int NBYTES = 256;
  localparam int MIN_FRAME = 4;
  localparam int QUERY_LEN = 8;
  localparam int REPLY_HDR = 3;
  localparam int MAX_REPLY_WORDS = 125;
  localparam int CHAR_BITS = 11;
  localparam int SIL_BITS = (CHAR_BITS * 7 + 1) / 2; // 3.5 characters, rounded up
  localparam int MS_PER_PERIOD = 100;                // period counted in 0.1 s
  localparam int BAUD_TAB [8] = '{4800, 9600, 19200, 38400, 57600, 115200, 230400, 256000};

  typedef enum logic [1:0] {ROLE_RESPOND = 2'h0, ROLE_POLL = 2'h1, ROLE_MONITOR = 2'h2} mbp_role_t;
  typedef enum logic [1:0] {
    eight_none_two_stop = 2'h0, eight_even_one_stop = 2'h1,
    eight_odd_one_stop = 2'h2, eight_none_one_stop = 2'h3
  } mbp_frame_t;
  typedef enum logic [3:0] {
    FMT_S8 = 4'h0, FMT_U8 = 4'h1, FMT_S16 = 4'h2, FMT_U16 = 4'h3, FMT_S32 = 4'h4,
    FMT_U32 = 4'h5, FMT_F32 = 4'h6, swapped_float_two_words = 4'h7, FMT_FLT_2W = 4'h8, FMT_LNG_2W = 4'h9
  } mbp_fmt_t;

  // clock cycles per bit
  function automatic logic [15:0] bit_div(input logic [2:0] sel);
    return 16'(CLK_HZ / BAUD_TAB[sel]);
  endfunction : bit_div

  // one byte into the modbus crc-16
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_step

  // formats that take two registers per value
  function automatic logic fmt_wide(input logic [3:0] f);
    return f >= FMT_S32;
  endfunction : fmt_wide

  // first and second register of a value into one 32-bit result
  function automatic logic [31:0] val_decode(input logic [3:0] f, input logic [15:0] w0, input logic [15:0] w1);
    case (f)
      FMT_S8:                 return {{24{w0[7]}}, w0[7:0]};
      FMT_U8:                 return {24'h000000, w0[7:0]};
      FMT_S16:                return {{16{w0[15]}}, w0};
      FMT_U16:                return {16'h0000, w0};
      FMT_FLT_2W, FMT_LNG_2W: return {w1, w0};
      default:                return {w0, w1};
    endcase
  endfunction : val_decode
endpackage : mbp_pkg

// [testbench/mbp_serial_port_monitor.sv]
// mbp_serial_port_monitor: port assertions for the modbus rtu serial port
// assumes it is bound into mbp_serial_port and sees only its ports
`timescale 1ns/100ps
module mbp_port_chk
  import mbp_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        tx_pin,
  input wire logic        tx_oe
);
  logic [7:0] addr_ff;
  logic [7:0] nxt_addr;
  // shadow of the station address written by software
  always_comb nxt_addr = (reg_wr && reg_addr == REG_CTRL) ? reg_wdata[7:0] : addr_ff;
  always_ff @(posedge clock) addr_ff <= srst ? CTRL_RST[7:0] : nxt_addr;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  property p_ctrl; s_wr(REG_CTRL) ##1 s_rd(REG_CTRL) |=> reg_rdata == {16'h0000, $past(reg_wdata[15:0], 2)}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_base; s_wr(REG_POLL) ##1 s_rd(REG_POLL) |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2); endproperty
  a_base: assert property (p_base) else $error("base register readback wrong");
  property p_count; s_wr(REG_POLL) ##1 s_rd(REG_POLL) |=> reg_rdata[21:16] ==
    (($past(reg_wdata[21:16], 2) > MAX_VALS) ? MAX_VALS : $past(reg_wdata[21:16], 2)); endproperty
  a_count: assert property (p_count) else $error("value count not clamped");
  property p_off; $rose(tx_oe) |-> addr_ff != 8'h00; endproperty
  a_off: assert property (p_off) else $error("frame sent with station address zero");
  property p_idle; !tx_oe |-> tx_pin; endproperty
  a_idle: assert property (p_idle) else $error("line not idle high");
  property p_start; $rose(tx_oe) |-> ##[0:2] !tx_pin; endproperty
  a_start: assert property (p_start) else $error("no start bit after enable");
  property p_stop; $fell(tx_oe) |-> $past(tx_pin); endproperty
  a_stop: assert property (p_stop) else $error("frame not closed by stop level");
  property p_rst; $fell(srst) |-> reg_rdata == 32'h0 && tx_pin && !tx_oe; endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset level");
endmodule : mbp_port_chk
bind mbp_serial_port mbp_port_chk i_chk (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_pin(tx_pin), .tx_oe(tx_oe));

// [testbench/mbp_serial_port_tb_top.sv]
// mbp_serial_port_tb_top: self-checking bench for the modbus rtu port
// assumes the station model drives rx and CYC_PER_MS is cut to 100
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module mbp_serial_port_tb_top;
  import mbp_pkg::*;
  localparam int DIV = 100000000 / 256000;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, d, v;
  logic        rx_line, tx_pin, tx_oe;
  logic [15:0] w0, w1;
  logic [7:0]  b, q [$];
  logic [7:0]  ra [7] = '{REG_CTRL, REG_POLL, REG_TIME, REG_STAT, REG_SEL, 8'h1C, 8'hFC};
  logic [31:0] rv [7] = '{CTRL_RST, POLL_RST, TIME_RST, 32'h0, 32'h0, 32'h0, 32'h0};
  int          errors = 0;
  int          checks_done = 0;
  int          seed = 32'h56EE7A80;
  int          n;
  mbp_serial_port #(.CYC_PER_MS(100)) i_dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_line), .tx_pin(tx_pin), .tx_oe(tx_oe));
  mbp_station_model i_peer (.clock(clock), .line(rx_line));
  always #5 clock = ~clock;
  // bus cycles, entered right after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    if (reg_wr) @(posedge clock); // let the previous strobe drop first
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= x;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata; // read data stand in this cycle only
    @(posedge clock);
  endtask : rd
  // expected value from two stored words
  function automatic logic [31:0] exp_val(input int f, input logic [15:0] p, input logic [15:0] r);
    case (f)
      0: return {{24{p[7]}}, p[7:0]};
      1: return {24'h000000, p[7:0]};
      2: return {{16{p[15]}}, p};
      3: return {16'h0000, p};
      8, 9: return {r, p}; // bytes 1,0 lead
      default: return {p, r}; // bytes 3,2 lead
    endcase
  endfunction : exp_val
  task automatic end_sim();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // one character from the port, sampled mid-bit
  task automatic get_char(output logic [7:0] c);
    n = 0;
    while (tx_pin !== 1'b0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 20000) begin
      errors++;
      end_sim();
    end
    repeat (DIV / 2) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(negedge clock);
      c[i] = tx_pin;
    end
    repeat (DIV) @(posedge clock);
  endtask : get_char
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    wr(8'h1C, 32'hFFFF_FFFF);
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(d, rv[i])
    end
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      wr(REG_CTRL, {16'h0, v[15], v[14:8] & 7'h7E, v[7:0]}); // role kept off poller
      rd(REG_CTRL);
      `CHK(d, {16'h0, v[15], v[14:8] & 7'h7E, v[7:0]})
      v[31:22] = {4'h0, 4'(v[27:24] % 10), 2'h0};
      if (i < 3) v[21:16] = 6'h32 + 6'(i);
      wr(REG_POLL, v);
      rd(REG_POLL);
      `CHK(d, {v[31:22], (v[21:16] > 6'h32) ? 6'h32 : v[21:16], v[15:0]})
    end
    for (int f = 0; f < 10; f++) begin
      w0 = 16'($random(seed)) | 16'h8080;
      w1 = 16'($random(seed));
      wr(REG_SEL, 32'h0);
      wr(REG_WORD, {16'h0, w0});
      wr(REG_SEL, 32'h1);
      wr(REG_WORD, {16'h0, w1});
      wr(REG_POLL, 32'(f) << 24);
      wr(REG_SEL, 32'h0);
      rd(REG_VAL);
      `CHK(d, exp_val(f, w0, w1))
    end
    // poller at once: continuous period, one u16 value, function 0x04, station 0x21
    wr(REG_TIME, 32'h0);
    wr(REG_POLL, 32'h0301_1234);
    wr(REG_CTRL, 32'h0000_F121);
    get_char(b);
    `CHK(b, 8'h21)
    rd(REG_STAT);
    `CHK(d[0], 1'b1)
    wr(REG_CTRL, 32'h0000_7000); // address zero stops the query
    @(posedge clock);
    rd(REG_STAT);
    `CHK(d[0], 1'b0)
    wr(REG_CTRL, 32'h0000_7005);
    q = '{8'h05, 8'h03};
    i_peer.send_frame(q, 1'b1, DIV);
    repeat (40 * DIV) @(posedge clock); // silence closes the frame
    `CHK(tx_oe, 1'b0)
    rd(REG_STAT);
    `CHK(d[15:8], 8'h01)
    q = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    i_peer.send_frame(q, 1'b0, DIV);
    get_char(b);
    `CHK(b, 8'h05)
    get_char(b);
    `CHK(b, 8'h03)
    get_char(b);
    `CHK(b, 8'h02)
    end_sim();
  end
endmodule : mbp_serial_port_tb_top

// [testbench/mbp_station_model.sv]
// mbp_station_model: remote rtu station sending frames on the port's receive line
// assumes 8n2 framing and a bit length given in clock cycles
`timescale 1ns/100ps
module mbp_station_model (
  input  wire logic clock,
  output logic      line
);
  initial line = 1'b1;
  // send a frame with crc appended low byte first, crc spoilt on request
  task automatic send_frame(input logic [7:0] q [$], input logic bad, input int div);
    logic [15:0] c;
    logic [10:0] ch;
    c = 16'hFFFF;
    foreach (q[k]) begin
      c = c ^ {8'h00, q[k]};
      for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    foreach (q[k]) begin
      ch = {2'b11, q[k], 1'b0}; // start, data lsb first, two stops
      for (int i = 0; i < 11; i++) begin
        line <= ch[i];
        repeat (div) @(posedge clock);
      end
    end
  endtask : send_frame
endmodule : mbp_station_model

// [verilog/mbp_serial_port.sv]
// mbp_serial_port: rs-485 modbus rtu port acting as responder, poller or monitor
// assumes one 100 MHz clock, an asynchronous rx pin and an external half-duplex transceiver
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module mbp_serial_port #(
  parameter int CYC_PER_MS = 100000
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             tx_oe
);
  import mbp_pkg::*;

  typedef enum logic [2:0] {U_IDLE = 3'h0, U_START = 3'h1, U_DATA = 3'h2, U_PAR = 3'h3, U_STOP = 3'h4} mbp_uart_t;
  typedef enum logic [1:0] {P_IDLE = 2'h0, P_SEND = 2'h1, P_WAIT = 2'h2, P_COPY = 2'h3} mbp_proto_t;
  localparam int MSW = $clog2(CYC_PER_MS);

  logic [15:0] word_mem [NWORDS];
  logic [7:0]  rx_buf [NBYTES];
  logic [31:0] ctrl_ff, poll_ff, time_ff, rdata_ff;
  logic [31:0] nxt_ctrl, nxt_poll, nxt_time, nxt_rdata, rval;
  logic [5:0]  sel_ff, nxt_sel;
  logic        rx_meta_ff, rx_sync_ff;
  mbp_uart_t   tx_st_ff, nxt_tx_st, rx_st_ff, nxt_rx_st;
  logic [15:0] tx_cnt_ff, nxt_tx_cnt, rx_cnt_ff, nxt_rx_cnt, bdiv;
  logic [2:0]  tx_bit_ff, nxt_tx_bit, rx_bit_ff, nxt_rx_bit;
  logic [7:0]  tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh, tx_data;
  logic        tx_pin_ff, nxt_tx_pin, tx_stop2_ff, nxt_tx_stop2, tx_go, tx_done;
  logic        rx_vld, rx_err;
  logic [19:0] sil_ff, nxt_sil, sil_lim;
  logic [8:0]  fr_len_ff, nxt_fr_len;
  logic [15:0] fr_crc_ff, nxt_fr_crc;
  logic        fr_bad_ff, nxt_fr_bad, fr_end, fr_ok, fr_take;
  logic [7:0]  bad_cnt_ff, nxt_bad_cnt;
  mbp_proto_t  pr_st_ff, nxt_pr_st;
  logic [8:0]  tx_idx_ff, nxt_tx_idx, tx_len_ff, nxt_tx_len, k;
  logic [15:0] tx_crc_ff, nxt_tx_crc, req_start, req_qty, tmo_cnt_ff, nxt_tmo_cnt;
  logic [7:0]  fn_ff, nxt_fn, nw_ff, nxt_nw, good_cnt_ff, nxt_good_cnt;
  logic [6:0]  rstart_ff, nxt_rstart, cp_ff, nxt_cp, wsel, vidx, mem_wa;
  logic [MSW-1:0] ms_cnt_ff, nxt_ms_cnt;
  logic [22:0] per_cnt_ff, nxt_per_cnt, per_lim;
  logic        tmo_flag_ff, nxt_tmo_flag, tx_oe_ff, nxt_tx_oe, ms_tick, port_on, mem_we;
  logic [15:0] mem_wd;
  logic [7:0]  own_addr, poll_fn, poll_nw;
  mbp_role_t   role;
  mbp_frame_t  frame;
  logic [3:0]  fmt;

  // configuration fields
  assign own_addr = ctrl_ff[CTRL_ADDR +: 8];
  assign role     = mbp_role_t'(ctrl_ff[CTRL_ROLE +: 2]);
  assign frame    = mbp_frame_t'(ctrl_ff[CTRL_FRAME +: 2]);
  assign fmt      = poll_ff[POLL_FMT +: 4];
  assign port_on  = own_addr != 8'h00;
  assign bdiv     = bit_div(ctrl_ff[CTRL_BAUD +: 3]);
  assign sil_lim  = 20'(bdiv * SIL_BITS);
  assign poll_fn  = ctrl_ff[CTRL_FN] ? FN_INPUT : FN_HOLD;
  assign poll_nw  = fmt_wide(fmt) ? {1'b0, poll_ff[POLL_CNT +: 6], 1'b0} : {2'b00, poll_ff[POLL_CNT +: 6]};
  assign per_lim  = 23'(time_ff[TIME_PER +: 16]) * 23'(MS_PER_PERIOD);
  assign vidx     = fmt_wide(fmt) ? {sel_ff, 1'b0} : {1'b0, sel_ff};

  // register writes and read data
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_poll = poll_ff;
    nxt_time = time_ff;
    nxt_sel  = sel_ff;
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        nxt_ctrl = {16'h0000, reg_wdata[15:0]};
      end else if (reg_addr == REG_POLL) begin
        nxt_poll = {4'h0, reg_wdata[27:24], 2'b00, reg_wdata[21:0]};
        if (reg_wdata[POLL_CNT +: 6] > MAX_VALS) nxt_poll[POLL_CNT +: 6] = MAX_VALS;
      end else if (reg_addr == REG_TIME) begin
        nxt_time = reg_wdata;
      end else if (reg_addr == REG_SEL) begin
        nxt_sel = reg_wdata[5:0];
      end
    end
    if (reg_addr == REG_CTRL) rval = ctrl_ff;
    else if (reg_addr == REG_POLL) rval = poll_ff;
    else if (reg_addr == REG_TIME) rval = time_ff;
    else if (reg_addr == REG_STAT) rval = {8'h00, good_cnt_ff, bad_cnt_ff, 6'h00, tmo_flag_ff, pr_st_ff != P_IDLE};
    else if (reg_addr == REG_SEL) rval = {26'h0, sel_ff};
    else if (reg_addr == REG_VAL) rval = val_decode(fmt, word_mem[vidx], word_mem[7'(vidx + 7'h1)]);
    else if (reg_addr == REG_WORD) rval = {16'h0000, word_mem[7'(sel_ff)]};
    else rval = 32'h0;
    nxt_rdata = reg_rd ? rval : 32'h0;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_ff  <= CTRL_RST;
      poll_ff  <= POLL_RST;
      time_ff  <= TIME_RST;
      sel_ff   <= 6'h00;
      rdata_ff <= 32'h0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      poll_ff  <= nxt_poll;
      time_ff  <= nxt_time;
      sel_ff   <= nxt_sel;
      rdata_ff <= nxt_rdata;
    end
  end

  // character transmitter, one state each for the start, data, parity and stop bits
  always_comb begin
    nxt_tx_st    = tx_st_ff;
    nxt_tx_cnt   = tx_cnt_ff;
    nxt_tx_bit   = tx_bit_ff;
    nxt_tx_sh    = tx_sh_ff;
    nxt_tx_pin   = tx_pin_ff;
    nxt_tx_stop2 = tx_stop2_ff;
    tx_done      = 1'b0;
    if (tx_cnt_ff != 16'h0000) begin
      nxt_tx_cnt = tx_cnt_ff - 16'h0001;
    end else begin
      case (tx_st_ff)
        U_IDLE: if (tx_go) begin
          nxt_tx_st  = U_START;
          nxt_tx_sh  = tx_data;
          nxt_tx_pin = 1'b0;
          nxt_tx_bit = 3'h0;
          nxt_tx_cnt = bdiv - 16'h0001;
        end
        U_START: begin
          nxt_tx_st  = U_DATA;
          nxt_tx_pin = tx_sh_ff[0];
          nxt_tx_cnt = bdiv - 16'h0001;
        end
        U_DATA: begin
          nxt_tx_cnt   = bdiv - 16'h0001;
          nxt_tx_bit   = tx_bit_ff + 3'h1;
          nxt_tx_stop2 = frame == eight_none_two_stop;
          if (tx_bit_ff != 3'h7) begin
            nxt_tx_pin = tx_sh_ff[nxt_tx_bit];
          end else if (frame == eight_even_one_stop || frame == eight_odd_one_stop) begin
            nxt_tx_st  = U_PAR;
            nxt_tx_pin = (^tx_sh_ff) ^ (frame == eight_odd_one_stop);
          end else begin
            nxt_tx_st  = U_STOP;
            nxt_tx_pin = 1'b1;
          end
        end
        U_PAR: begin
          nxt_tx_st  = U_STOP;
          nxt_tx_pin = 1'b1;
          nxt_tx_cnt = bdiv - 16'h0001;
        end
        default: if (tx_stop2_ff) begin
          nxt_tx_stop2 = 1'b0;
          nxt_tx_cnt   = bdiv - 16'h0001;
        end else begin
          nxt_tx_st = U_IDLE;
          tx_done   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_st_ff    <= U_IDLE;
      tx_cnt_ff   <= 16'h0000;
      tx_bit_ff   <= 3'h0;
      tx_sh_ff    <= 8'h00;
      tx_pin_ff   <= 1'b1;
      tx_stop2_ff <= 1'b0;
    end else begin
      tx_st_ff    <= nxt_tx_st;
      tx_cnt_ff   <= nxt_tx_cnt;
      tx_bit_ff   <= nxt_tx_bit;
      tx_sh_ff    <= nxt_tx_sh;
      tx_pin_ff   <= nxt_tx_pin;
      tx_stop2_ff <= nxt_tx_stop2;
    end
  end

  // character receiver, sampling mid-bit on the synchronised line
  always_comb begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh  = rx_sh_ff;
    rx_vld     = 1'b0;
    rx_err     = 1'b0;
    if (rx_cnt_ff != 16'h0000) begin
      nxt_rx_cnt = rx_cnt_ff - 16'h0001;
    end else begin
      case (rx_st_ff)
        U_IDLE: if (!rx_sync_ff) begin
          nxt_rx_st  = U_START;
          nxt_rx_cnt = bdiv >> 1;
        end
        U_START: begin
          nxt_rx_st  = rx_sync_ff ? U_IDLE : U_DATA; // a glitch is no start bit
          nxt_rx_bit = 3'h0;
          nxt_rx_cnt = bdiv - 16'h0001;
        end
        U_DATA: begin
          nxt_rx_sh  = {rx_sync_ff, rx_sh_ff[7:1]};
          nxt_rx_bit = rx_bit_ff + 3'h1;
          nxt_rx_cnt = bdiv - 16'h0001;
          if (rx_bit_ff == 3'h7) begin
            nxt_rx_st = (frame == eight_even_one_stop || frame == eight_odd_one_stop) ? U_PAR : U_STOP;
          end
        end
        U_PAR: begin
          nxt_rx_st  = U_STOP;
          nxt_rx_cnt = bdiv - 16'h0001;
          nxt_rx_sh  = rx_sh_ff;
          if (rx_sync_ff != ((^rx_sh_ff) ^ (frame == eight_odd_one_stop))) nxt_rx_bit = 3'h1; // parity fault mark
        end
        default: begin
          nxt_rx_st = U_IDLE;
          rx_vld    = 1'b1;
          rx_err    = !rx_sync_ff || rx_bit_ff == 3'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_st_ff   <= U_IDLE;
      rx_cnt_ff  <= 16'h0000;
      rx_bit_ff  <= 3'h0;
      rx_sh_ff   <= 8'h00;
    end else begin
      rx_meta_ff <= rx_pin;
      rx_sync_ff <= rx_meta_ff;
      rx_st_ff   <= nxt_rx_st;
      rx_cnt_ff  <= nxt_rx_cnt;
      rx_bit_ff  <= nxt_rx_bit;
      rx_sh_ff   <= nxt_rx_sh;
    end
  end

  // frame assembly, crc check and end-of-frame silence
  assign fr_take = rx_vld && port_on && pr_st_ff != P_SEND;
  assign fr_end  = sil_ff == sil_lim && fr_len_ff != 9'h000;
  assign fr_ok   = fr_crc_ff == 16'h0000 && !fr_bad_ff && fr_len_ff >= 9'(MIN_FRAME);
  always_comb begin
    nxt_sil     = (rx_st_ff != U_IDLE || !rx_sync_ff) ? 20'h00000 : (sil_ff == sil_lim ? sil_ff : sil_ff + 20'h00001);
    nxt_fr_len  = fr_len_ff;
    nxt_fr_crc  = fr_crc_ff;
    nxt_fr_bad  = fr_bad_ff;
    nxt_bad_cnt = bad_cnt_ff;
    if (fr_end) begin
      nxt_fr_len = 9'h000;
      nxt_fr_crc = CRC_INIT;
      nxt_fr_bad = 1'b0;
      if (!fr_ok) nxt_bad_cnt = bad_cnt_ff + 8'h01;
    end else if (fr_take) begin
      nxt_fr_crc = crc_step(fr_crc_ff, rx_sh_ff);
      nxt_fr_bad = fr_bad_ff || rx_err || fr_len_ff == 9'(NBYTES);
      if (fr_len_ff != 9'(NBYTES)) nxt_fr_len = fr_len_ff + 9'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (fr_take && fr_len_ff != 9'(NBYTES)) rx_buf[fr_len_ff[7:0]] <= rx_sh_ff;
    if (srst) begin
      sil_ff     <= 20'h00000;
      fr_len_ff  <= 9'h000;
      fr_crc_ff  <= CRC_INIT;
      fr_bad_ff  <= 1'b0;
      bad_cnt_ff <= 8'h00;
    end else begin
      sil_ff     <= nxt_sil;
      fr_len_ff  <= nxt_fr_len;
      fr_crc_ff  <= nxt_fr_crc;
      fr_bad_ff  <= nxt_fr_bad;
      bad_cnt_ff <= nxt_bad_cnt;
    end
  end

  // outgoing byte: query, reply header, register data or crc
  assign k         = tx_idx_ff - 9'(REPLY_HDR);
  assign wsel      = rstart_ff + k[7:1];
  assign req_start = {rx_buf[2], rx_buf[3]};
  assign req_qty   = {rx_buf[4], rx_buf[5]};
  always_comb begin
    if (tx_idx_ff == tx_len_ff - 9'h002) tx_data = tx_crc_ff[7:0];
    else if (tx_idx_ff == tx_len_ff - 9'h001) tx_data = tx_crc_ff[15:8];
    else if (tx_idx_ff == 9'h000) tx_data = own_addr;
    else if (tx_idx_ff == 9'h001) tx_data = fn_ff;
    else if (role == ROLE_POLL && tx_idx_ff == 9'h002) tx_data = poll_ff[POLL_BASE + 8 +: 8];
    else if (role == ROLE_POLL && tx_idx_ff == 9'h003) tx_data = poll_ff[POLL_BASE +: 8];
    else if (role == ROLE_POLL && tx_idx_ff == 9'h004) tx_data = 8'h00;
    else if (role == ROLE_POLL) tx_data = nw_ff;
    else if (tx_idx_ff == 9'h002) tx_data = {nw_ff[6:0], 1'b0};
    else tx_data = k[0] ? word_mem[wsel][7:0] : word_mem[wsel][15:8];
  end

  // protocol sequencer for the three roles
  always_comb begin
    nxt_pr_st    = pr_st_ff;
    nxt_tx_idx   = tx_idx_ff;
    nxt_tx_len   = tx_len_ff;
    nxt_tx_crc   = tx_crc_ff;
    nxt_fn       = fn_ff;
    nxt_nw       = nw_ff;
    nxt_rstart   = rstart_ff;
    nxt_cp       = cp_ff;
    nxt_good_cnt = good_cnt_ff;
    nxt_tmo_cnt  = tmo_cnt_ff;
    ms_tick      = ms_cnt_ff == MSW'(CYC_PER_MS - 1);
    nxt_ms_cnt   = ms_tick ? '0 : ms_cnt_ff + MSW'(1);
    nxt_per_cnt  = (ms_tick && per_cnt_ff < per_lim) ? per_cnt_ff + 23'h000001 : per_cnt_ff;
    nxt_tmo_flag = tmo_flag_ff && !(reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_TMO]);
    tx_go        = 1'b0;
    case (pr_st_ff)
      P_IDLE: if (role == ROLE_POLL && per_cnt_ff >= per_lim && poll_nw != 8'h00) begin
        nxt_pr_st   = P_SEND;
        nxt_per_cnt = 23'h000000;
        nxt_tx_len  = 9'(QUERY_LEN);
        nxt_tx_idx  = 9'h000;
        nxt_tx_crc  = CRC_INIT;
        nxt_fn      = poll_fn;
        nxt_nw      = poll_nw;
      end else if (fr_end && fr_ok && rx_buf[0] == own_addr && (rx_buf[1] == FN_HOLD || rx_buf[1] == FN_INPUT)) begin
        nxt_fn  = rx_buf[1];
        nxt_nw  = req_qty[7:0];
        nxt_tmo_cnt = 16'h0000;
        if (role == ROLE_RESPOND && req_qty != 16'h0000 && req_qty <= 16'(MAX_REPLY_WORDS)
            && 17'(req_start) + 17'(req_qty) <= 17'(NWORDS)) begin
          nxt_pr_st  = P_SEND;
          nxt_rstart = req_start[6:0];
          nxt_tx_len = 9'(req_qty) * 9'h002 + 9'(REPLY_HDR + 2);
          nxt_tx_idx = 9'h000;
          nxt_tx_crc = CRC_INIT;
        end else if (role == ROLE_MONITOR && fr_len_ff == 9'(QUERY_LEN) && req_start == poll_ff[POLL_BASE +: 16]
                     && req_qty == 16'(poll_nw) && poll_nw != 8'h00) begin
          nxt_pr_st = P_WAIT;
        end
      end
      P_SEND: if (tx_st_ff == U_IDLE && tx_cnt_ff == 16'h0000 && !tx_done) begin
        if (tx_idx_ff == tx_len_ff) begin
          nxt_pr_st   = role == ROLE_POLL ? P_WAIT : P_IDLE;
          nxt_tmo_cnt = 16'h0000;
        end else begin
          tx_go      = 1'b1;
          nxt_tx_idx = tx_idx_ff + 9'h001;
          if (tx_idx_ff < tx_len_ff - 9'h002) nxt_tx_crc = crc_step(tx_crc_ff, tx_data);
        end
      end
      P_WAIT: if (fr_end && fr_ok && rx_buf[0] == own_addr && rx_buf[1] == fn_ff && rx_buf[2] == {nw_ff[6:0], 1'b0}) begin
        nxt_pr_st = P_COPY;
        nxt_cp    = 7'h00;
      end else if (ms_tick) begin
        nxt_tmo_cnt = tmo_cnt_ff + 16'h0001;
        if (tmo_cnt_ff >= time_ff[TIME_TMO +: 16]) begin
          nxt_pr_st    = P_IDLE;
          nxt_tmo_flag = 1'b1;
        end
      end
      default: begin
        nxt_cp = cp_ff + 7'h01;
        if (8'(cp_ff) == nw_ff - 8'h01) begin
          nxt_pr_st    = P_IDLE;
          nxt_good_cnt = good_cnt_ff + 8'h01;
        end
      end
    endcase
    if (!port_on) nxt_pr_st = P_IDLE;
    nxt_tx_oe = nxt_pr_st == P_SEND || tx_st_ff != U_IDLE;
  end

  // register store: copied reply data, or software writes for the responder
  always_comb begin
    mem_we = 1'b0;
    mem_wa = 7'(sel_ff);
    mem_wd = reg_wdata[15:0];
    if (pr_st_ff == P_COPY) begin
      mem_we = 1'b1;
      mem_wa = cp_ff;
      mem_wd = {rx_buf[8'({cp_ff, 1'b0}) + 8'(REPLY_HDR)], rx_buf[8'({cp_ff, 1'b0}) + 8'(REPLY_HDR + 1)]};
    end else if (reg_wr && reg_addr == REG_WORD) begin
      mem_we = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (mem_we) word_mem[mem_wa] <= mem_wd;
    if (srst) begin
      pr_st_ff    <= P_IDLE;
      tx_idx_ff   <= 9'h000;
      tx_len_ff   <= 9'h000;
      tx_crc_ff   <= CRC_INIT;
      fn_ff       <= FN_HOLD;
      nw_ff       <= 8'h00;
      rstart_ff   <= 7'h00;
      cp_ff       <= 7'h00;
      good_cnt_ff <= 8'h00;
      tmo_cnt_ff  <= 16'h0000;
      ms_cnt_ff   <= '0;
      per_cnt_ff  <= 23'h000000;
      tmo_flag_ff <= 1'b0;
      tx_oe_ff    <= 1'b0;
    end else begin
      pr_st_ff    <= nxt_pr_st;
      tx_idx_ff   <= nxt_tx_idx;
      tx_len_ff   <= nxt_tx_len;
      tx_crc_ff   <= nxt_tx_crc;
      fn_ff       <= nxt_fn;
      nw_ff       <= nxt_nw;
      rstart_ff   <= nxt_rstart;
      cp_ff       <= nxt_cp;
      good_cnt_ff <= nxt_good_cnt;
      tmo_cnt_ff  <= nxt_tmo_cnt;
      ms_cnt_ff   <= nxt_ms_cnt;
      per_cnt_ff  <= nxt_per_cnt;
      tmo_flag_ff <= nxt_tmo_flag;
      tx_oe_ff    <= nxt_tx_oe;
    end
  end

  assign reg_rdata = rdata_ff;
  assign tx_pin    = tx_pin_ff;
  assign tx_oe     = tx_oe_ff;
endmodule : mbp_serial_port
